//--- logic/lane_cfg_pkg.sv
package lane_cfg_pkg;

    // Register byte addresses (printed offsets are indices; byte address = 4x)
    localparam logic [11:0] IDX_EXTRA_A    = 12'h20a;
    localparam logic [11:0] IDX_EXTRA_B    = 12'h20b;
    localparam logic [11:0] IDX_SH_MODE    = 12'h20f;
    localparam logic [11:0] IDX_LINK_CTRL  = 12'h220;
    localparam logic [11:0] IDX_LANE_STAT  = 12'h221;
    localparam logic [11:0] IDX_SH_STAT    = 12'h222;
    localparam logic [13:0] ADDR_EXTRA_A   = {IDX_EXTRA_A, 2'b00};
    localparam logic [13:0] ADDR_EXTRA_B   = {IDX_EXTRA_B, 2'b00};
    localparam logic [13:0] ADDR_SH_MODE   = {IDX_SH_MODE, 2'b00};
    localparam logic [13:0] ADDR_LINK_CTRL = {IDX_LINK_CTRL, 2'b00};
    localparam logic [13:0] ADDR_LANE_STAT = {IDX_LANE_STAT, 2'b00};
    localparam logic [13:0] ADDR_SH_STAT   = {IDX_SH_STAT, 2'b00};

    // Field layout
    localparam int          SER_BIT        = 0;
    localparam int          LANE_LSB       = 1;
    localparam int          LANE_MSB       = 7;
    localparam int          LANES          = 8;
    localparam logic [7:0]  RESET_BYTE     = 8'h00;
    localparam int          LINK_EN_BIT    = 0;
    localparam int          PD_A_BIT       = 1;
    localparam int          PD_B_BIT       = 2;
    localparam int          MODE_66_BIT    = 3;

    // Test pattern codes
    localparam logic [3:0]  TP_NONE        = 4'h0;
    localparam logic [3:0]  TP_RAMP        = 4'h4;
    localparam logic [3:0]  TP_ALT         = 4'h5;

    typedef enum logic [1:0] {
        SH_CRC12 = 2'b00,
        SH_RSV1  = 2'b01,
        SH_FEC   = 2'b10,
        SH_RSV3  = 2'b11
    } sh_mode_t;

    typedef enum logic [1:0] {
        SHO_NONE  = 2'b00,
        SHO_CRC12 = 2'b01,
        SHO_FEC   = 2'b10
    } sh_out_t;

    localparam logic [31:0] CMD_IDLE       = 32'h0000_0000;

endpackage

//--- logic/cfg_word_if.sv
`timescale 1ns/100ps
interface cfg_word_if;
    logic        valid;
    logic        ready;
    logic [31:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

//--- logic/lane_apb_slave.sv
`timescale 1ns/100ps
module lane_apb_slave
    import lane_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Register side
    output logic      [7:0]  extra_a,
    output logic      [7:0]  extra_b,
    output logic      [7:0]  sh_mode,
    output logic      [7:0]  link_ctrl,
    input  wire logic [31:0] stat_lane,
    input  wire logic [31:0] stat_sh
);
    logic [7:0]  extra_a_q;
    logic [7:0]  extra_b_q;
    logic [7:0]  sh_mode_q;
    logic [7:0]  link_ctrl_q;
    logic [31:0] prdata_q;
    logic        slverr_q;

    wire  [13:0] word_addr = paddr[15:2];
    wire         hit_a     = word_addr == {2'h0, IDX_EXTRA_A};
    wire         hit_b     = word_addr == {2'h0, IDX_EXTRA_B};
    wire         hit_sh    = word_addr == {2'h0, IDX_SH_MODE};
    wire         hit_ctl   = word_addr == {2'h0, IDX_LINK_CTRL};
    wire         hit_ls    = word_addr == {2'h0, IDX_LANE_STAT};
    wire         hit_ss    = word_addr == {2'h0, IDX_SH_STAT};
    wire         mapped    = hit_a | hit_b | hit_sh | hit_ctl | hit_ls | hit_ss;
    wire         setup     = psel & ~penable;
    wire         wr_go     = psel & penable & pwrite & mapped & pstrb[0];
    wire         bad       = ~mapped | (pwrite & (hit_ls | hit_ss));
    wire  [31:0] rd_mux    = hit_a   ? {24'h0, extra_a_q}   :
                             hit_b   ? {24'h0, extra_b_q}   :
                             hit_sh  ? {24'h0, sh_mode_q}   :
                             hit_ctl ? {24'h0, link_ctrl_q} :
                             hit_ls  ? stat_lane            :
                             hit_ss  ? stat_sh : 32'h0;

    // Answer in the cycle after setup; one access cycle
    assign pready    = psel & penable;
    assign prdata    = prdata_q;
    assign pslverr   = slverr_q & psel & penable;
    assign extra_a   = extra_a_q;
    assign extra_b   = extra_b_q;
    assign sh_mode   = sh_mode_q;
    assign link_ctrl = link_ctrl_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extra_a_q   <= RESET_BYTE;
            extra_b_q   <= RESET_BYTE;
            sh_mode_q   <= RESET_BYTE;
            link_ctrl_q <= RESET_BYTE;
            prdata_q    <= 32'h0;
            slverr_q    <= 1'b0;
        end else begin
            if (setup) begin
                prdata_q <= pwrite ? 32'h0 : rd_mux;
                slverr_q <= bad;
            end
            if (wr_go && hit_a) extra_a_q <= pwdata[7:0];
            if (wr_go && hit_b) extra_b_q <= pwdata[7:0];
            if (wr_go && hit_sh) sh_mode_q <= pwdata[7:0];
            if (wr_go && hit_ctl) link_ctrl_q <= pwdata[7:0];
        end
    end
endmodule

//--- logic/word_buf2.sv
`timescale 1ns/100ps
module word_buf2 #(
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Ports
    cfg_word_if.dst   up,
    cfg_word_if.src   dn
);
    if (DEPTH != 2) begin : g_depth_check
        $error("word_buf2 supports depth 2 only");
    end

    logic [31:0] mem_q [DEPTH];
    logic        wp_q;
    logic        rp_q;
    logic [1:0]  cnt_q;

    wire push = up.valid & up.ready;
    wire pop  = dn.valid & dn.ready;

    assign up.ready = cnt_q != 2'd2;
    assign dn.valid = cnt_q != 2'd0;
    assign dn.data  = mem_q[rp_q];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'd0;
            mem_q[0] <= 32'h0;
            mem_q[1] <= 32'h0;
        end else begin
            if (push) mem_q[wp_q] <= up.data;
            if (push) wp_q <= ~wp_q;
            if (pop) rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

//--- logic/lane_cfg_top.sv
`timescale 1ns/100ps
module lane_cfg_top
    import lane_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Link mode inputs
    input  wire logic [7:0]  mode_lanes_a,
    input  wire logic [7:0]  mode_lanes_b,
    input  wire logic [3:0]  test_pattern_select,
    // Lane controls
    output logic      [7:0]  lane_clk_en_a,
    output logic      [7:0]  lane_clk_en_b,
    output logic      [7:0]  lane_ser_en_a,
    output logic      [7:0]  lane_ser_en_b,
    output logic      [7:0]  lane_ramp_a,
    output logic      [7:0]  lane_ramp_b,
    output logic      [3:0]  lane_test_sel,
    output logic      [1:0]  sh_content,
    // Sync-header command stream and live-write flag
    output logic             cmd_valid,
    input  wire logic        cmd_ready,
    output logic      [31:0] cmd_word,
    output logic             write_while_live
);
    logic [7:0] extra_a;
    logic [7:0] extra_b;
    logic [7:0] sh_mode;
    logic [7:0] link_ctrl;
    logic [7:0] clk_a_q;
    logic [7:0] clk_b_q;
    logic [7:0] ser_a_q;
    logic [7:0] ser_b_q;
    logic [7:0] ramp_a_q;
    logic [7:0] ramp_b_q;
    logic [3:0] test_q;
    logic [1:0] shc_q;
    logic       wlive_q;

    cfg_word_if cmd_in ();
    cfg_word_if cmd_out ();

    lane_apb_slave u_apb (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .pstrb     (pstrb),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .extra_a   (extra_a),
        .extra_b   (extra_b),
        .sh_mode   (sh_mode),
        .link_ctrl (link_ctrl),
        .stat_lane ({ser_b_q, ser_a_q, clk_b_q, clk_a_q}),
        .stat_sh   ({23'h0, wlive_q, 2'b00, shc_q, test_q})
    );

    // Contiguous-from-zero mask
    function automatic logic [7:0] contig(input logic [7:0] en);
        logic [7:0] m;
        m    = 8'h00;
        m[0] = en[0];
        for (int i = 1; i < LANES; i++) begin
            m[i] = m[i-1] & en[i];
        end
        return m;
    endfunction

    // Lane enable computation per link
    function automatic logic [7:0] lanes_on(input logic [7:0] mode,
                                            input logic [7:0] xtra,
                                            input logic       pd);
        logic [7:0] req;
        req = mode | {xtra[LANE_MSB:LANE_LSB], 1'b0};
        return pd ? 8'h00 : req;
    endfunction

    wire       link_en = link_ctrl[LINK_EN_BIT];
    wire       pd_a    = link_ctrl[PD_A_BIT];
    wire       pd_b    = link_ctrl[PD_B_BIT];
    wire       m66     = link_ctrl[MODE_66_BIT];
    wire [7:0] on_a    = lanes_on(mode_lanes_a, extra_a, pd_a);
    wire [7:0] on_b    = lanes_on(mode_lanes_b, extra_b, pd_b);
    wire [7:0] only_a  = on_a & ~mode_lanes_a;
    wire [7:0] only_b  = on_b & ~mode_lanes_b;
    wire [7:0] sera_d  = contig(on_a) & (mode_lanes_a |
                         (extra_a[SER_BIT] ? only_a : 8'h00));
    wire [7:0] serb_d  = contig(on_b) & (mode_lanes_b |
                         (extra_b[SER_BIT] ? only_b : 8'h00));
    wire       ramp_tp = test_pattern_select == TP_NONE ||
                         test_pattern_select == TP_ALT;
    wire [7:0] rampa_d = ramp_tp ? only_a : 8'h00;
    wire [7:0] rampb_d = ramp_tp ? only_b : 8'h00;
    wire [1:0] shc_d   = !m66 ? SHO_NONE :
                         sh_mode[1:0] == SH_CRC12 ? SHO_CRC12 :
                         sh_mode[1:0] == SH_FEC ? SHO_FEC : SHO_NONE;
    wire       cfg_wr  = psel & penable & pwrite & pstrb[0] &
                         (paddr[15:2] == {2'h0, IDX_EXTRA_A} ||
                          paddr[15:2] == {2'h0, IDX_EXTRA_B} ||
                          paddr[15:2] == {2'h0, IDX_SH_MODE});

    // Idle command words into the two-entry buffer
    assign cmd_in.valid = link_en & m66;
    assign cmd_in.data  = CMD_IDLE;

    word_buf2 #(
        .DEPTH (2)
    ) u_buf (
        .pclk    (pclk),
        .presetn (presetn),
        .up      (cmd_in.dst),
        .dn      (cmd_out.src)
    );

    assign cmd_valid       = cmd_out.valid;
    assign cmd_word        = cmd_out.data;
    assign cmd_out.ready   = cmd_ready;
    assign lane_clk_en_a   = clk_a_q;
    assign lane_clk_en_b   = clk_b_q;
    assign lane_ser_en_a   = ser_a_q;
    assign lane_ser_en_b   = ser_b_q;
    assign lane_ramp_a     = ramp_a_q;
    assign lane_ramp_b     = ramp_b_q;
    assign lane_test_sel   = test_q;
    assign sh_content      = shc_q;
    assign write_while_live = wlive_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_a_q  <= RESET_BYTE;
            clk_b_q  <= RESET_BYTE;
            ser_a_q  <= RESET_BYTE;
            ser_b_q  <= RESET_BYTE;
            ramp_a_q <= RESET_BYTE;
            ramp_b_q <= RESET_BYTE;
            test_q   <= TP_NONE;
            shc_q    <= SHO_NONE;
        end else begin
            clk_a_q  <= on_a;
            clk_b_q  <= on_b;
            ser_a_q  <= sera_d;
            ser_b_q  <= serb_d;
            ramp_a_q <= rampa_d;
            ramp_b_q <= rampb_d;
            test_q   <= test_pattern_select;
            shc_q    <= shc_d;
        end
    end

    // Sticky flag for extra_a, extra_b or sh_mode writes made while the link runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wlive_q <= 1'b0;
        end else if (cfg_wr && link_en) begin
            wlive_q <= 1'b1;
        end
    end

    default clocking cb_chk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_pd_a_off: assert property (@(posedge pclk) disable iff (!presetn)
        pd_a |=> clk_a_q == 8'h00 && ser_a_q == 8'h00)
        else $error("lane A active while powered down");

    chk_extra_a_clk: assert property (@(posedge pclk) disable iff (!presetn)
        (!pd_a && extra_a[3]) |=> clk_a_q[3])
        else $error("extra lane A3 clock missing");

    chk_extra_b_clk: assert property (@(posedge pclk) disable iff (!presetn)
        (!pd_b && extra_b[5]) |=> clk_b_q[5])
        else $error("extra lane B5 clock missing");

    chk_ser_clk_only: assert property (
        (!extra_a[SER_BIT] && mode_lanes_a == 8'h00) |=> ser_a_q == 8'h00)
        else $error("serializer on in clock-only mode");

    chk_ser_contig: assert property (@(posedge pclk) disable iff (!presetn)
        ser_a_q[4] |-> &clk_a_q[3:0])
        else $error("serializer clocked without lower lanes");

    sequence ramp_cause;
        ramp_tp && only_b[2];
    endsequence
    chk_ramp_b: assert property (
        ramp_cause |=> ramp_b_q[2] && test_q == $past(test_pattern_select))
        else $error("extra-only lane B2 not ramping");

    chk_sh_fec: assert property (@(posedge pclk) disable iff (!presetn)
        (m66 && sh_mode[1:0] == SH_FEC) |=> sh_content == SHO_FEC)
        else $error("FEC sync header not selected");

    chk_sh_8b10b: assert property (@(posedge pclk) disable iff (!presetn)
        !m66 |=> sh_content == SHO_NONE)
        else $error("sync header active in 8b/10b mode");

    chk_cmd_idle: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_valid |-> cmd_word == CMD_IDLE)
        else $error("non-idle command word");

    chk_wlive_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_wr && link_en) |=> write_while_live [*2])
        else $error("live write not flagged");

    chk_wlive_sticky: assert property (
        write_while_live |=> write_while_live)
        else $error("live write flag cleared");

    chk_wlive_quiet: assert property (
        (!write_while_live && !(cfg_wr && link_en)) |=> !write_while_live)
        else $error("live write flag set without cause");

    chk_pd_b_off: assert property (
        pd_b |=> clk_b_q == 8'h00 && ser_b_q == 8'h00)
        else $error("lane B active while powered down");

    chk_pd_a_ramp: assert property (
        pd_a |=> ramp_a_q == 8'h00)
        else $error("lane A ramping while powered down");

    chk_extra_a7_clk: assert property (
        (!pd_a && extra_a[7]) |=> clk_a_q[7])
        else $error("extra lane A7 clock missing");

    chk_extra_b1_clk: assert property (
        (!pd_b && extra_b[1]) |=> clk_b_q[1])
        else $error("extra lane B1 clock missing");

    chk_no_extra_a: assert property (
        (mode_lanes_a == 8'h00 && extra_a[LANE_MSB:LANE_LSB] == 7'h00)
        |=> clk_a_q == 8'h00)
        else $error("lane A clock without enable");

    chk_mode_a_clk: assert property (
        (!pd_a && mode_lanes_a[0]) |=> clk_a_q[0])
        else $error("mode lane A0 clock missing");

    chk_ser_extra_a: assert property (
        (!pd_a && extra_a[SER_BIT] && extra_a[2:1] == 2'h3 &&
         mode_lanes_a[0]) |=> ser_a_q[2:0] == 3'h7)
        else $error("extra serializers A1 A2 not powered");

    chk_ser_clk_b: assert property (
        (!extra_b[SER_BIT] && mode_lanes_b == 8'h00) |=> ser_b_q == 8'h00)
        else $error("serializer B on in clock-only mode");

    chk_ser_contig_b: assert property (
        ser_b_q[3] |-> clk_b_q[2:0] == 3'h7)
        else $error("serializer B3 clocked without lower lanes");

    chk_ser_gap_a: assert property (
        !clk_a_q[0] |-> ser_a_q == 8'h00)
        else $error("serializer A on without lane 0");

    chk_ramp_mode_a: assert property (
        mode_lanes_a[1] |=> !ramp_a_q[1])
        else $error("mode lane A1 sends ramp");

    chk_ramp_tp_b: assert property (
        test_pattern_select == TP_RAMP |=> ramp_b_q == 8'h00)
        else $error("lane B ramp flag with explicit test pattern");

    chk_test_follow: assert property (
        presetn |=> lane_test_sel == $past(test_pattern_select))
        else $error("test selection not passed to lanes");

    chk_sh_crc12: assert property (
        (m66 && sh_mode[1:0] == SH_CRC12) |=> sh_content == SHO_CRC12)
        else $error("CRC-12 sync header not selected");

    chk_sh_reserved: assert property (
        sh_mode[0] |=> sh_content == SHO_NONE)
        else $error("reserved sync header code used");

    chk_cmd_8b10b: assert property (
        (!m66 && !cmd_valid) |=> !cmd_valid)
        else $error("command word outside 64b/66b mode");

    sequence fill_req;
        link_en && m66 && !cmd_valid;
    endsequence
    chk_cmd_fill: assert property (
        fill_req |=> cmd_valid)
        else $error("idle command word not offered");

    chk_cmd_hold: assert property (
        (cmd_valid && !cmd_ready) |=> cmd_valid && $stable(cmd_word))
        else $error("command word lost during stall");
endmodule

//--- verification/cmd_sink.sv
`timescale 1ns/100ps
module cmd_sink (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Command stream
    input  wire logic        cmd_valid,
    input  wire logic [31:0] cmd_word,
    output logic             cmd_ready,
    // Pace: 0 stall, 1 random, 2 always ready
    input  wire logic [1:0]  pace,
    output logic      [15:0] n_words,
    output logic      [15:0] n_bad
);
    logic [15:0] lfsr_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_q    <= 16'hace1;
            cmd_ready <= 1'b0;
            n_words   <= 16'h0;
            n_bad     <= 16'h0;
        end else begin
            lfsr_q    <= {lfsr_q[14:0],
                          lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            cmd_ready <= (pace == 2'd2) || (pace == 2'd1 && lfsr_q[0]);
            if (cmd_valid && cmd_ready) begin
                n_words <= n_words + 16'h1;
                if (cmd_word != 32'h0) begin
                    n_bad <= n_bad + 16'h1;
                end
            end
        end
    end
endmodule

//--- verification/lane_cfg_top_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module lane_cfg_top_tb;
    import lane_cfg_pkg::*;
    localparam logic [15:0] A_XA = {2'b00, ADDR_EXTRA_A};
    localparam logic [15:0] A_XB = {2'b00, ADDR_EXTRA_B};
    localparam logic [15:0] A_SH = {2'b00, ADDR_SH_MODE};
    localparam logic [15:0] A_LC = {2'b00, ADDR_LINK_CTRL};
    localparam logic [15:0] A_LS = {2'b00, ADDR_LANE_STAT};
    localparam logic [15:0] A_SS = {2'b00, ADDR_SH_STAT};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        cmd_valid, cmd_ready, write_while_live, pda, pdb;
    logic [15:0] paddr, n_words, n_bad, la, lb;
    logic [31:0] pwdata, prdata, cmd_word, rnd;
    logic [3:0]  pstrb, strb_v, test_pattern_select, lane_test_sel, tp;
    logic [7:0]  mode_lanes_a, mode_lanes_b, clk_a, clk_b, ser_a, ser_b;
    logic [7:0]  ramp_a, ramp_b, ea, eb, ma, mb, ra, rb;
    logic [1:0]  sh_content, pace;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [3:0]  tps [4] = '{TP_NONE, TP_RAMP, TP_ALT, 4'h2};
    logic [1:0]  shx [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
    int          n_errors, num_checks;

    lane_cfg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mode_lanes_a(mode_lanes_a), .mode_lanes_b(mode_lanes_b),
        .test_pattern_select(test_pattern_select), .lane_clk_en_a(clk_a),
        .lane_clk_en_b(clk_b), .lane_ser_en_a(ser_a), .lane_ser_en_b(ser_b),
        .lane_ramp_a(ramp_a), .lane_ramp_b(ramp_b),
        .lane_test_sel(lane_test_sel), .sh_content(sh_content),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
        .write_while_live(write_while_live));
    cmd_sink sink (.pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid),
        .cmd_word(cmd_word), .cmd_ready(cmd_ready), .pace(pace),
        .n_words(n_words), .n_bad(n_bad));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Expected {serializer, clock} enables of one link
    function automatic logic [15:0] lane_exp(input logic [7:0] ex, m,
                                             input logic pd);
        logic [7:0] c, s;
        logic       p;
        c = (m | {ex[7:1], 1'b0}) & {8{!pd}};
        p = 1'b1;
        for (int n = 0; n < 8; n++) begin
            s[n] = p & (ex[0] ? c[n] : m[n] & c[n]);
            p = p & c[n];
        end
        return {s, c};
    endfunction

    task apb(input logic [15:0] a, input logic w, input logic [31:0] d,
             input logic [33:0] x);
        exp_q.push_back(x);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        pstrb   <= strb_v;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d, input logic err);
        apb(a, 1'b1, {24'h0, d}, {1'b0, err, 32'h0});
    endtask

    task rd(input logic [15:0] a, input logic [31:0] d, input logic err);
        apb(a, 1'b0, 32'h0, {1'b1, err, d});
    endtask

    // Response monitor
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            `CHK("pslverr", e[32], pslverr)
            if (e[33]) `CHK("prdata", e[31:0], prdata)
        end
    end

    task end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        $display("test watchdog expired");
        end_of_test();
    end

    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        {paddr, pwdata, pstrb, strb_v} = {16'h0, 32'h0, 4'hf, 4'hf};
        {mode_lanes_a, mode_lanes_b, test_pattern_select} = 20'h0;
        pace = 2'd0;
        rnd = 32'h8f1f;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(A_XA, 32'h0, 1'b0);
        rd(A_XB, 32'h0, 1'b0);
        rd(A_SH, 32'h0, 1'b0);
        rd(16'h0900, 32'h0, 1'b1);
        wr(A_LS, 8'hff, 1'b1);
        $display("test reset_map done");
        for (int i = 0; i < 12; i++) begin
            rnd = xs(rnd);
            {eb, ea} = rnd[15:0];
            ma = 8'hff >> rnd[18:16];
            mb = 8'hff >> rnd[21:19];
            pda = &rnd[23:22];
            pdb = &rnd[25:24];
            tp = tps[rnd[27:26]];
            wr(A_XA, ea, 1'b0);
            wr(A_XB, eb, 1'b0);
            wr(A_LC, {5'h0, pdb, pda, 1'b0}, 1'b0);
            mode_lanes_a <= ma;
            mode_lanes_b <= mb;
            test_pattern_select <= tp;
            repeat (2) @(posedge pclk);
            la = lane_exp(ea, ma, pda);
            lb = lane_exp(eb, mb, pdb);
            rd(A_LS, {lb[15:8], la[15:8], lb[7:0], la[7:0]}, 1'b0);
            ra = (tp == TP_NONE || tp == TP_ALT) ? la[7:0] & ~ma : 8'h00;
            rb = (tp == TP_NONE || tp == TP_ALT) ? lb[7:0] & ~mb : 8'h00;
            `CHK("lane_ramp_a", ra, ramp_a)
            `CHK("lane_ramp_b", rb, ramp_b)
            `CHK("lane_test_sel", tp, lane_test_sel)
            `CHK("lane_clk_en_a", la[7:0], clk_a)
            `CHK("lane_clk_en_b", lb[7:0], clk_b)
            `CHK("lane_ser_en_a", la[15:8], ser_a)
            `CHK("lane_ser_en_b", lb[15:8], ser_b)
        end
        $display("test lanes done");
        strb_v = 4'he;
        wr(A_XA, 8'h55, 1'b0);
        strb_v = 4'hf;
        rd(A_XA, {24'h0, ea}, 1'b0);
        $display("test strobe done");
        for (int c = 0; c < 4; c++) begin
            wr(A_SH, 8'(c), 1'b0);
            wr(A_LC, 8'h09, 1'b0);
            repeat (2) @(posedge pclk);
            `CHK("sh_content", shx[c], sh_content)
            `CHK("cmd_valid", 1'b1, cmd_valid)
            `CHK("cmd_word", CMD_IDLE, cmd_word)
            wr(A_LC, 8'h01, 1'b0);
            repeat (2) @(posedge pclk);
            `CHK("sh_content", 2'h0, sh_content)
            wr(A_LC, 8'h00, 1'b0);
        end
        $display("test sync_header done");
        wr(A_LC, 8'h09, 1'b0);
        pace <= 2'd1;
        repeat (60) @(posedge pclk);
        wr(A_LC, 8'h00, 1'b0);
        pace <= 2'd2;
        repeat (10) @(posedge pclk);
        `CHK("cmd_valid", 1'b0, cmd_valid)
        `CHK("n_bad", 16'h0, n_bad)
        `CHK("n_words", 1'b1, n_words > 16'd4)
        $display("test stream done");
        `CHK("write_while_live", 1'b0, write_while_live)
        wr(A_LC, 8'h01, 1'b0);
        wr(A_XA, 8'h02, 1'b0);
        `CHK("write_while_live", 1'b1, write_while_live)
        rd(A_SS, {23'h0, 1'b1, 4'h0, tp}, 1'b0);
        $display("test live_write done");
        end_of_test();
    end
endmodule
